// ==== src/pin_mux_pkg.sv ====
package pin_mux_pkg;
  localparam logic [11:0] OFF_PORT_A_DATA = 12'h000;
  localparam logic [11:0] OFF_PORT_A_DIR = 12'h004;
  localparam logic [11:0] OFF_PORT_B_DATA = 12'h008;
  localparam logic [11:0] OFF_PORT_B_DIR = 12'h00C;
  localparam logic [11:0] OFF_PORT_B_HIGH_OUTPUT_SELECT = 12'h010;
  localparam logic [11:0] OFF_INPUT_SOURCE_SELECT_0 = 12'h014;
  localparam logic [11:0] OFF_INPUT_SOURCE_SELECT_1 = 12'h018;
  localparam logic [11:0] OFF_READBACK_TEST_KEY = 12'h01C;
  localparam logic [11:0] OFF_WAKE_ENABLE = 12'h020;
  localparam logic [11:0] OFF_BIT_OP = 12'h024;

  localparam int PORT_W = 7;
  localparam logic [6:0] PORT_RESET = 7'h7F;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [7:0] KEY_RESET = 8'h00;
  localparam logic [6:0] WAKE_RESET = 7'h00;
  localparam logic [7:0] READBACK_KEY = 8'hCA;
  localparam logic [7:0] SEL_IMPL_MASK = 8'h3F;

  localparam int PB6_FIELD_LSB = 4;
  localparam int PB5_FIELD_LSB = 2;
  localparam int PERIODIC_TIMER_CAPTURE_IN_FIELD_LSB = 6;
  localparam int SCS_FIELD_LSB = 4;
  localparam int SCK_FIELD_LSB = 2;
  localparam int SDI_FIELD_LSB = 0;
  localparam int EXTERNAL_INTERRUPT_ZERO_FIELD_LSB = 4;
  localparam int STANDARD_TIMER_CAPTURE_IN_FIELD_LSB = 2;
  localparam int STANDARD_TIMER_CLOCK_IN_FIELD_LSB = 0;

  localparam int BITOP_IDX_LSB = 0;
  localparam int BITOP_SET_BIT = 3;
  localparam int BITOP_TGT_LSB = 4;
  localparam logic [1:0] TGT_A_DATA = 2'b00;
  localparam logic [1:0] TGT_A_DIR = 2'b01;
  localparam logic [1:0] TGT_B_DATA = 2'b10;
  localparam logic [1:0] TGT_B_DIR = 2'b11;

  localparam logic [1:0] CODE_00 = 2'b00;
  localparam logic [1:0] CODE_01 = 2'b01;
  localparam logic [1:0] CODE_10 = 2'b10;
  localparam logic [1:0] CODE_11 = 2'b11;
endpackage

// ==== src/pin_input_mux_and_readback_test.sv ====
// Contract
// [RULE_01] Top two selector bits read zero
// [RULE_02] PB6 code 01 gives powerline data
// [RULE_03] PB5 selects GPIO, timers, powerline reference
// [RULE_04] Reserved low bits stay plain storage
// [RULE_05] Periodic capture from comparator except 01
// [RULE_06] Chip select from PA5 or PA1
// [RULE_07] Serial clock from PB2 or PA0
// [RULE_08] Serial data from PB3, PA2, PA6
// [RULE_09] Interrupt zero and capture fixed pins
// [RULE_10] Timer clock from PA5 or PA3
// [RULE_11] Key byte enables readback, reset disabled
// [RULE_12] Other values disable readback mode
// [RULE_13] Readback returns live pin levels
// [RULE_14] Readback touches only the read path
// [RULE_15] Normal read: pin, latch or zero
// [RULE_16] A/D path open unless analog selected
// [RULE_17] Readback forces selected A/D path closed
// [RULE_18] Port data and direction reset high
// [RULE_19] Bit set and clear are read-modify-write
// [RULE_20] Enabled port A falling edge wakes
// [RULE_21] Selectors read back last written value
`timescale 1ns/100ps
module pin_input_mux_and_readback_test (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [pin_mux_pkg::PORT_W-1:0] port_a_pin_in,
  input wire logic [pin_mux_pkg::PORT_W-1:0] port_b_pin_in,
  output logic [pin_mux_pkg::PORT_W-1:0] port_a_pin_out,
  output logic [pin_mux_pkg::PORT_W-1:0] port_a_pin_oe,
  output logic [pin_mux_pkg::PORT_W-1:0] port_b_pin_out,
  output logic [pin_mux_pkg::PORT_W-1:0] port_b_pin_oe,
  input wire logic [pin_mux_pkg::PORT_W-1:0] port_a_analog_func,
  input wire logic [pin_mux_pkg::PORT_W-1:0] port_b_analog_func,
  input wire logic [pin_mux_pkg::PORT_W-1:0] port_a_serial_func,
  input wire logic [pin_mux_pkg::PORT_W-1:0] port_b_serial_func,
  input wire logic standard_timer_output,
  input wire logic periodic_timer_output,
  input wire logic powerline_data_io_out,
  input wire logic powerline_data_io_oe,
  input wire logic powerline_comparator_out,
  output logic powerline_data_io_in,
  output logic powerline_reference_sel,
  output logic periodic_timer_capture_in,
  output logic serial_chip_select_in,
  output logic serial_clock_in,
  output logic uart_receive_path,
  output logic external_interrupt_zero,
  output logic standard_timer_capture_in,
  output logic standard_timer_clock_in,
  input wire logic [1:0] adc_channel_sel,
  input wire logic [3:0] adc_analog_func,
  output logic [3:0] adc_path_closed,
  output logic readback_enable_internal,
  input wire logic sleep_mode,
  output logic wake_request
);
  import pin_mux_pkg::*;

  function automatic logic pick4(input logic [1:0] code, input logic v0, input logic v1,
                                 input logic v2, input logic v3);
    logic r;
    r = v0;
    case (code)
      CODE_00: r = v0;
      CODE_01: r = v1;
      CODE_10: r = v2;
      CODE_11: r = v3;
      default: r = v0;
    endcase
    return r;
  endfunction

  function automatic logic [6:0] port_read(input logic [6:0] pin, input logic [6:0] latch,
                                           input logic [6:0] dir, input logic [6:0] analog,
                                           input logic [6:0] serial, input logic rb);
    logic [6:0] r;
    r = 7'h00;
    for (int i = 0; i < PORT_W; i++) begin
      if (rb) begin
        r[i] = pin[i]; // [RULE_13]
      end else if (analog[i]) begin
        r[i] = 1'b0; // [RULE_15]
      end else if (serial[i] || dir[i]) begin
        r[i] = pin[i]; // [RULE_15]
      end else begin
        r[i] = latch[i]; // [RULE_15]
      end
    end
    return r;
  endfunction

  logic [6:0] pa_s1_q, pa_s2_q, pa_s3_q, pa_q;
  logic [6:0] pb_s1_q, pb_s2_q, pb_s3_q, pb_q;
  logic [6:0] pa_data_q, pa_dir_q, pb_data_q, pb_dir_q;
  logic [7:0] pbh_sel_q, src0_q, src1_q, key_q;
  logic [6:0] wake_en_q;
  logic rb_en_q;
  logic [1:0] pb6_field, pb5_field;
  logic [6:0] pb_analog_all, pb_serial_all, pa_rd, pb_rd;
  logic acc, wr, bit_op;
  logic [2:0] op_idx;
  logic [1:0] op_tgt;
  logic op_set;
  logic [6:0] op_src, op_res;
  logic [7:0] wbyte;
  logic [7:0] rd_d;
  logic hit_d;

  assign pb6_field = pbh_sel_q[PB6_FIELD_LSB +: 2];
  assign pb5_field = pbh_sel_q[PB5_FIELD_LSB +: 2];
  assign pb_analog_all = port_b_analog_func | {1'b0, (pb5_field == CODE_11), 5'b0};
  assign pb_serial_all = port_b_serial_func;
  assign pa_rd = port_read(pa_q, pa_data_q, pa_dir_q, port_a_analog_func,
                           port_a_serial_func, rb_en_q);
  assign pb_rd = port_read(pb_q, pb_data_q, pb_dir_q, pb_analog_all,
                           pb_serial_all, rb_en_q);

  // The second and third stages must agree before a pin change is accepted.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_s1_q <= PORT_RESET;
      pa_s2_q <= PORT_RESET;
      pa_s3_q <= PORT_RESET;
      pa_q <= PORT_RESET;
      pb_s1_q <= PORT_RESET;
      pb_s2_q <= PORT_RESET;
      pb_s3_q <= PORT_RESET;
      pb_q <= PORT_RESET;
    end else begin
      pa_s1_q <= port_a_pin_in;
      pa_s2_q <= pa_s1_q;
      pa_s3_q <= pa_s2_q;
      pb_s1_q <= port_b_pin_in;
      pb_s2_q <= pb_s1_q;
      pb_s3_q <= pb_s2_q;
      for (int i = 0; i < PORT_W; i++) begin
        if (pa_s2_q[i] == pa_s3_q[i]) begin
          pa_q[i] <= pa_s3_q[i];
        end
        if (pb_s2_q[i] == pb_s3_q[i]) begin
          pb_q[i] <= pb_s3_q[i];
        end
      end
    end
  end

  // Bus handshake: one wait state, write takes effect with pready high.
  assign acc = psel && penable;
  assign wr = acc && pwrite && pready && pstrb[0];
  assign wbyte = pwdata[7:0];
  assign bit_op = wr && (paddr == OFF_BIT_OP);
  assign op_idx = wbyte[BITOP_IDX_LSB +: 3];
  assign op_set = wbyte[BITOP_SET_BIT];
  assign op_tgt = wbyte[BITOP_TGT_LSB +: 2];

  always_comb begin
    op_src = pa_rd;
    case (op_tgt)
      TGT_A_DATA: op_src = pa_rd;
      TGT_A_DIR: op_src = pa_dir_q;
      TGT_B_DATA: op_src = pb_rd;
      TGT_B_DIR: op_src = pb_dir_q;
      default: op_src = pa_rd;
    endcase
    op_res = op_src;
    if (op_idx < 3'd7) begin
      op_res[op_idx] = op_set; // [RULE_19]
    end
  end

  always_comb begin
    rd_d = 8'h00;
    hit_d = 1'b1;
    case (paddr)
      OFF_PORT_A_DATA: rd_d = {1'b0, pa_rd};
      OFF_PORT_A_DIR: rd_d = {1'b0, pa_dir_q};
      OFF_PORT_B_DATA: rd_d = {1'b0, pb_rd};
      OFF_PORT_B_DIR: rd_d = {1'b0, pb_dir_q};
      OFF_PORT_B_HIGH_OUTPUT_SELECT: rd_d = pbh_sel_q & SEL_IMPL_MASK; // [RULE_01] [RULE_21]
      OFF_INPUT_SOURCE_SELECT_0: rd_d = src0_q; // [RULE_21]
      OFF_INPUT_SOURCE_SELECT_1: rd_d = src1_q & SEL_IMPL_MASK; // [RULE_01] [RULE_21]
      OFF_READBACK_TEST_KEY: rd_d = key_q; // [RULE_21]
      OFF_WAKE_ENABLE: rd_d = {1'b0, wake_en_q};
      OFF_BIT_OP: rd_d = 8'h00;
      default: hit_d = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc && !pready;
      if (acc && !pready) begin
        pslverr <= !hit_d;
        prdata <= (pwrite || !hit_d) ? 32'h0000_0000 : {24'h00_0000, rd_d};
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_data_q <= PORT_RESET; // [RULE_18]
      pa_dir_q <= PORT_RESET; // [RULE_18]
      pb_data_q <= PORT_RESET; // [RULE_18]
      pb_dir_q <= PORT_RESET; // [RULE_18]
    end else if (bit_op) begin
      case (op_tgt)
        TGT_A_DATA: pa_data_q <= op_res; // [RULE_19]
        TGT_A_DIR: pa_dir_q <= op_res; // [RULE_19]
        TGT_B_DATA: pb_data_q <= op_res; // [RULE_19]
        TGT_B_DIR: pb_dir_q <= op_res; // [RULE_19]
        default: pa_data_q <= pa_data_q;
      endcase
    end else if (wr) begin
      if (paddr == OFF_PORT_A_DATA) begin
        pa_data_q <= wbyte[6:0];
      end
      if (paddr == OFF_PORT_A_DIR) begin
        pa_dir_q <= wbyte[6:0];
      end
      if (paddr == OFF_PORT_B_DATA) begin
        pb_data_q <= wbyte[6:0];
      end
      if (paddr == OFF_PORT_B_DIR) begin
        pb_dir_q <= wbyte[6:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pbh_sel_q <= SEL_RESET;
      src0_q <= SEL_RESET;
      src1_q <= SEL_RESET;
      wake_en_q <= WAKE_RESET;
    end else if (wr) begin
      if (paddr == OFF_PORT_B_HIGH_OUTPUT_SELECT) begin
        pbh_sel_q <= wbyte & SEL_IMPL_MASK; // [RULE_01] [RULE_04]
      end
      if (paddr == OFF_INPUT_SOURCE_SELECT_0) begin
        src0_q <= wbyte;
      end
      if (paddr == OFF_INPUT_SOURCE_SELECT_1) begin
        src1_q <= wbyte & SEL_IMPL_MASK; // [RULE_01]
      end
      if (paddr == OFF_WAKE_ENABLE) begin
        wake_en_q <= wbyte[6:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_q <= KEY_RESET; // [RULE_11]
      rb_en_q <= 1'b0; // [RULE_11]
    end else if (wr && paddr == OFF_READBACK_TEST_KEY) begin
      key_q <= wbyte;
      rb_en_q <= (wbyte == READBACK_KEY); // [RULE_11] [RULE_12]
    end
  end

  // Pin drive depends on selectors, latches, analog functions and peripheral outputs, never on readback mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_pin_out <= PORT_RESET;
      port_a_pin_oe <= 7'h00;
      port_b_pin_out <= PORT_RESET;
      port_b_pin_oe <= 7'h00;
      powerline_data_io_in <= 1'b0;
      powerline_reference_sel <= 1'b0;
    end else begin
      port_a_pin_out <= pa_data_q; // [RULE_14]
      port_a_pin_oe <= ~pa_dir_q & ~port_a_analog_func; // [RULE_14]
      for (int i = 0; i < 5; i++) begin
        port_b_pin_out[i] <= pb_data_q[i];
        port_b_pin_oe[i] <= ~pb_dir_q[i] & ~port_b_analog_func[i];
      end
      port_b_pin_out[5] <= pick4(pb5_field, pb_data_q[5], standard_timer_output,
                                 periodic_timer_output, 1'b0); // [RULE_03]
      port_b_pin_oe[5] <= pick4(pb5_field, ~pb_dir_q[5] & ~port_b_analog_func[5],
                                1'b1, 1'b1, 1'b0); // [RULE_03]
      powerline_reference_sel <= (pb5_field == CODE_11); // [RULE_03]
      if (pb6_field == CODE_01) begin
        port_b_pin_out[6] <= powerline_data_io_out; // [RULE_02]
        port_b_pin_oe[6] <= powerline_data_io_oe; // [RULE_02]
      end else begin
        port_b_pin_out[6] <= pb_data_q[6]; // [RULE_02]
        port_b_pin_oe[6] <= ~pb_dir_q[6] & ~port_b_analog_func[6]; // [RULE_02]
      end
      powerline_data_io_in <= (pb6_field == CODE_01) && pb_q[6]; // [RULE_02]
    end
  end

  // Reserved codes feed either an idle level or the code 00 source to the peripheral input.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periodic_timer_capture_in <= 1'b0;
      serial_chip_select_in <= 1'b1;
      serial_clock_in <= 1'b0;
      uart_receive_path <= 1'b1;
      external_interrupt_zero <= 1'b0;
      standard_timer_capture_in <= 1'b0;
      standard_timer_clock_in <= 1'b0;
    end else begin
      periodic_timer_capture_in <= pick4(src0_q[PERIODIC_TIMER_CAPTURE_IN_FIELD_LSB +: 2], powerline_comparator_out,
                                         1'b0, powerline_comparator_out,
                                         powerline_comparator_out); // [RULE_05]
      serial_chip_select_in <= pick4(src0_q[SCS_FIELD_LSB +: 2], pa_q[5], 1'b1,
                                     pa_q[1], pa_q[5]); // [RULE_06]
      serial_clock_in <= pick4(src0_q[SCK_FIELD_LSB +: 2], pb_q[2], pa_q[0],
                               1'b0, pb_q[2]); // [RULE_07]
      uart_receive_path <= pick4(src0_q[SDI_FIELD_LSB +: 2], pb_q[3], pa_q[2],
                                 pa_q[6], pb_q[3]); // [RULE_08]
      external_interrupt_zero <= pick4(src1_q[EXTERNAL_INTERRUPT_ZERO_FIELD_LSB +: 2], pb_q[0], 1'b0,
                                       pb_q[0], pb_q[0]); // [RULE_09]
      standard_timer_capture_in <= pick4(src1_q[STANDARD_TIMER_CAPTURE_IN_FIELD_LSB +: 2], pb_q[1], 1'b0,
                                         pb_q[1], pb_q[1]); // [RULE_09]
      standard_timer_clock_in <= pick4(src1_q[STANDARD_TIMER_CLOCK_IN_FIELD_LSB +: 2], pa_q[3], pa_q[5],
                                       pa_q[3], pa_q[3]); // [RULE_10]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_path_closed <= 4'h0;
      readback_enable_internal <= 1'b0;
    end else begin
      readback_enable_internal <= rb_en_q;
      for (int c = 0; c < 4; c++) begin
        adc_path_closed[c] <= (adc_channel_sel == c[1:0]) &&
                              (adc_analog_func[c] || rb_en_q); // [RULE_16] [RULE_17]
      end
    end
  end

  // The previous filtered level provides the falling-edge reference.
  logic [6:0] pa_prev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_prev_q <= PORT_RESET;
      wake_request <= 1'b0;
    end else begin
      pa_prev_q <= pa_q;
      wake_request <= sleep_mode && |(pa_prev_q & ~pa_q & wake_en_q); // [RULE_20]
    end
  end
endmodule

// ==== verif/pin_far_side_model.sv ====
`timescale 1ns/100ps
module pin_far_side_model (
  input wire logic [6:0] a_out,
  input wire logic [6:0] a_oe,
  input wire logic [6:0] b_out,
  input wire logic [6:0] b_oe,
  input wire logic [6:0] a_ext,
  input wire logic [6:0] b_ext,
  input wire logic shorted,
  output logic [6:0] a_pin,
  output logic [6:0] b_pin
);
  // A driven pin shows its own output unless the board holds it hard at its own level.
  assign a_pin = shorted ? a_ext : (a_oe & a_out) | (~a_oe & a_ext);
  assign b_pin = shorted ? b_ext : (b_oe & b_out) | (~b_oe & b_ext);
endmodule

// ==== verif/pin_mux_sva.sv ====
`timescale 1ns/100ps
module pin_mux_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [pin_mux_pkg::PORT_W-1:0] port_a_pin_oe,
  input wire logic [pin_mux_pkg::PORT_W-1:0] port_b_pin_oe,
  input wire logic powerline_reference_sel,
  input wire logic [1:0] adc_channel_sel,
  input wire logic [3:0] adc_path_closed,
  input wire logic readback_enable_internal,
  input wire logic sleep_mode,
  input wire logic wake_request
);
  import pin_mux_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_key_done;
    psel && penable && pready && pwrite && paddr == OFF_READBACK_TEST_KEY;
  endsequence
  sequence s_read_done;
    psel && penable && pready && !pwrite;
  endsequence
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready did not follow the wait state");
  a_err_unmapped: assert property (psel && penable && !pready && paddr > OFF_BIT_OP
    |=> pslverr) else $error("unmapped access without error");
  a_top_bits_zero: assert property (s_read_done ##0
    (paddr == OFF_PORT_B_HIGH_OUTPUT_SELECT || paddr == OFF_INPUT_SOURCE_SELECT_1)
    |-> prdata[7:6] == 2'h0) else $error("top bits set");
  a_key_enables: assert property (s_key_done ##0 pwdata[7:0] == READBACK_KEY
    |-> ##3 readback_enable_internal) else $error("key did not enable readback");
  a_other_disables: assert property (s_key_done ##0 pwdata[7:0] != READBACK_KEY
    |-> ##3 !readback_enable_internal) else $error("readback stayed on");
  a_forced_path: assert property (readback_enable_internal
    && $past(readback_enable_internal, 2) && $stable(adc_channel_sel)
    |-> adc_path_closed == 4'h1 << adc_channel_sel)
    else $error("readback did not close the channel path");
  a_path_one_channel: assert property (adc_path_closed != 4'h0
    && $stable(adc_channel_sel) |-> adc_path_closed == 4'h1 << adc_channel_sel)
    else $error("wrong path closed");
  a_ref_released: assert property (powerline_reference_sel |-> !port_b_pin_oe[5])
    else $error("reference pin still driven");
  a_wake_pulse: assert property (wake_request
    |-> $past(sleep_mode) ##1 !wake_request) else $error("bad wake pulse");
  a_reset_inputs: assert property ($rose(presetn)
    |-> port_a_pin_oe == '0 && port_b_pin_oe == '0) else $error("pins driven after reset");
endmodule
bind pin_input_mux_and_readback_test pin_mux_sva sva (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .port_a_pin_oe, .port_b_pin_oe,
  .powerline_reference_sel, .adc_channel_sel, .adc_path_closed, .readback_enable_internal,
  .sleep_mode, .wake_request);

// ==== verif/pin_input_mux_and_readback_test_test.sv ====
`timescale 1ns/100ps
module pin_input_mux_and_readback_test_test;
  import pin_mux_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, powerline_data_io_in, powerline_reference_sel, periodic_timer_capture_in;
  logic serial_chip_select_in, serial_clock_in, uart_receive_path, external_interrupt_zero;
  logic standard_timer_capture_in, standard_timer_clock_in, readback_enable_internal, wake_request;
  logic [6:0] port_a_pin_in, port_b_pin_in, port_a_pin_out, port_a_pin_oe, port_b_pin_out;
  logic [6:0] port_b_pin_oe, port_a_analog_func = '0, port_b_analog_func = '0;
  logic [6:0] port_a_serial_func = '0, port_b_serial_func = '0, a_ext = 7'h7F, b_ext = 7'h7F;
  logic standard_timer_output = 1'b0, periodic_timer_output = 1'b0, powerline_data_io_out = 1'b0;
  logic powerline_data_io_oe = 1'b0, powerline_comparator_out = 1'b0, sleep_mode = 1'b0;
  logic shorted = 1'b0, er;
  logic [1:0] adc_channel_sel = '0;
  logic [3:0] adc_analog_func = '0, adc_path_closed;
  logic [7:0] rd;
  int n_mismatch = 0, checks = 0;
  always #10 pclk = ~pclk;
  pin_input_mux_and_readback_test DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .port_a_pin_in, .port_b_pin_in, .port_a_pin_out,
    .port_a_pin_oe, .port_b_pin_out, .port_b_pin_oe, .port_a_analog_func, .port_b_analog_func,
    .port_a_serial_func, .port_b_serial_func, .standard_timer_output, .periodic_timer_output,
    .powerline_data_io_out, .powerline_data_io_oe, .powerline_comparator_out, .powerline_data_io_in,
    .powerline_reference_sel, .periodic_timer_capture_in, .serial_chip_select_in, .serial_clock_in,
    .uart_receive_path, .external_interrupt_zero, .standard_timer_capture_in,
    .standard_timer_clock_in, .adc_channel_sel, .adc_analog_func, .adc_path_closed,
    .readback_enable_internal, .sleep_mode, .wake_request);
  pin_far_side_model far (.a_out(port_a_pin_out), .a_oe(port_a_pin_oe), .b_out(port_b_pin_out),
    .b_oe(port_b_pin_oe), .a_ext, .b_ext, .shorted, .a_pin(port_a_pin_in), .b_pin(port_b_pin_in));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic w(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input string nm, input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(nm, {8'h00, rd}, {8'h00, e});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  function automatic logic [6:0] route(logic [1:0] c, logic [6:0] a, logic [6:0] b, logic k);
    route[6] = c == 2'h1 ? 1'b0 : k;
    route[5] = c == 2'h1 ? 1'b1 : (c == 2'h2 ? a[1] : a[5]);
    route[4] = c == 2'h2 ? 1'b0 : (c == 2'h1 ? a[0] : b[2]);
    route[3] = c == 2'h1 ? a[2] : (c == 2'h2 ? a[6] : b[3]);
    route[2] = c == 2'h1 ? 1'b0 : b[0];
    route[1] = c == 2'h1 ? 1'b0 : b[1];
    route[0] = c == 2'h1 ? a[5] : a[3];
  endfunction
  task automatic t_reset();
    for (int i = 0; i < 8; i++) rc("reset value", 12'(4 * i), i < 4 ? 8'h7F : 8'h00);
    chk("readback at reset", {15'h0, readback_enable_internal}, 16'h0000);
    apb(1'b0, 12'h040, 8'h00);
    chk("unmapped error", {15'h0, er}, 16'h0001);
  endtask
  task automatic t_sel();
    w(OFF_PORT_B_HIGH_OUTPUT_SELECT, 8'hFC);
    w(OFF_INPUT_SOURCE_SELECT_0, 8'hFF);
    w(OFF_INPUT_SOURCE_SELECT_1, 8'hFF);
    pstrb <= 4'h0;
    w(OFF_INPUT_SOURCE_SELECT_0, 8'h00);
    pstrb <= 4'hF;
    rc("b high select", OFF_PORT_B_HIGH_OUTPUT_SELECT, 8'h3C);
    rc("source select 0", OFF_INPUT_SOURCE_SELECT_0, 8'hFF);
    rc("source select 1", OFF_INPUT_SOURCE_SELECT_1, 8'h3F);
  endtask
  task automatic t_route();
    logic [1:0] c;
    logic [6:0] r;
    for (int i = 0; i < 8; i++) begin
      c = 2'(i / 2);
      w(OFF_INPUT_SOURCE_SELECT_0, {4{c}});
      w(OFF_INPUT_SOURCE_SELECT_1, {2'h0, {3{c}}});
      a_ext <= i[0] ? 7'h46 : 7'h61;
      b_ext <= i[0] ? 7'h06 : 7'h09;
      powerline_comparator_out <= ~i[0];
      tick(7);
      r = route(c, a_ext, b_ext, powerline_comparator_out);
      chk("periodic capture", {15'h0, periodic_timer_capture_in}, {15'h0, r[6]});
      chk("chip select", {15'h0, serial_chip_select_in}, {15'h0, r[5]});
      chk("serial clock", {15'h0, serial_clock_in}, {15'h0, r[4]});
      chk("serial data", {15'h0, uart_receive_path}, {15'h0, r[3]});
      chk("interrupt zero", {15'h0, external_interrupt_zero}, {15'h0, r[2]});
      chk("timer capture", {15'h0, standard_timer_capture_in}, {15'h0, r[1]});
      chk("timer clock", {15'h0, standard_timer_clock_in}, {15'h0, r[0]});
    end
  endtask
  task automatic t_pb();
    logic [1:0] c, e, f;
    w(OFF_PORT_B_DATA, 8'h00);
    w(OFF_PORT_B_DIR, 8'h5F);
    for (int i = 0; i < 8; i++) begin
      c = 2'(i / 2);
      w(OFF_PORT_B_HIGH_OUTPUT_SELECT, {2'h0, c, c, 2'h0});
      standard_timer_output <= i[0];
      periodic_timer_output <= ~i[0];
      powerline_data_io_out <= ~i[0];
      powerline_data_io_oe <= 1'b1;
      b_ext <= {~i[0], 6'h00};
      tick(7);
      e = {c != 2'h3, c == 2'h1 ? i[0] : (c == 2'h2 ? ~i[0] : 1'b0)};
      f = {c == 2'h1, c == 2'h1 & ~i[0]};
      chk("pb5 reference", {15'h0, powerline_reference_sel}, {15'h0, c == 2'h3});
      chk("pb5 drive", {14'h0, port_b_pin_oe[5], port_b_pin_out[5]}, {14'h0, e});
      chk("pb6 drive", {14'h0, port_b_pin_oe[6], port_b_pin_out[6]}, {14'h0, f});
      chk("pb6 input", {15'h0, powerline_data_io_in}, {15'h0, f[0]});
    end
  endtask
  task automatic t_rb();
    logic [13:0] drive;
    w(OFF_PORT_A_DATA, 8'h0F);
    w(OFF_PORT_A_DIR, 8'h01);
    port_a_analog_func <= 7'h40;
    port_a_serial_func <= 7'h20;
    a_ext <= 7'h70;
    shorted <= 1'b1;
    adc_channel_sel <= 2'h1;
    tick(7);
    drive = {port_a_pin_out, port_a_pin_oe};
    rc("normal port read", OFF_PORT_A_DATA, 8'h2E);
    chk("open path", {12'h0, adc_path_closed}, 16'h0000);
    adc_analog_func <= 4'h2;
    tick(3);
    chk("analog path", {12'h0, adc_path_closed}, 16'h0002);
    adc_analog_func <= 4'h0;
    w(OFF_READBACK_TEST_KEY, READBACK_KEY);
    tick(4);
    chk("readback on", {15'h0, readback_enable_internal}, 16'h0001);
    rc("readback port read", OFF_PORT_A_DATA, 8'h70);
    chk("forced path", {12'h0, adc_path_closed}, 16'h0002);
    chk("pin drive", {2'h0, drive}, {2'h0, port_a_pin_out, port_a_pin_oe});
    rc("key readback", OFF_READBACK_TEST_KEY, READBACK_KEY);
    w(OFF_READBACK_TEST_KEY, 8'hCB);
    tick(4);
    chk("readback off", {15'h0, readback_enable_internal}, 16'h0000);
    rc("latch read again", OFF_PORT_A_DATA, 8'h2E);
    shorted <= 1'b0;
    port_a_analog_func <= '0;
    port_a_serial_func <= '0;
  endtask
  task automatic t_bitop();
    w(OFF_PORT_A_DATA, 8'h00);
    w(OFF_PORT_A_DIR, 8'h7E);
    a_ext <= 7'h7F;
    tick(7);
    w(OFF_BIT_OP, {2'h0, TGT_A_DATA, 1'b1, 3'h0});
    w(OFF_PORT_A_DIR, 8'h00);
    tick(2);
    chk("latch after bit set", {9'h0, port_a_pin_out}, 16'h007F);
    w(OFF_BIT_OP, {2'h0, TGT_B_DIR, 1'b0, 3'h3});
    rc("dir after bit clear", OFF_PORT_B_DIR, 8'h57);
    w(OFF_BIT_OP, {2'h0, TGT_B_DATA, 1'b1, 3'h3});
    rc("b data after bit set", OFF_PORT_B_DATA, 8'h08);
    w(OFF_BIT_OP, {2'h0, TGT_A_DIR, 1'b1, 3'h6});
    rc("a dir after bit set", OFF_PORT_A_DIR, 8'h40);
  endtask
  task automatic fall(input logic [6:0] v, input logic [7:0] n_exp);
    logic [7:0] n;
    n = 8'h00;
    a_ext <= v;
    repeat (10) begin
      @(posedge pclk);
      if (wake_request === 1'b1) n++;
    end
    chk("wake pulses", {8'h00, n}, {8'h00, n_exp});
    a_ext <= 7'h7F;
    tick(8);
  endtask
  task automatic t_wake();
    w(OFF_PORT_A_DIR, 8'h7F);
    w(OFF_WAKE_ENABLE, 8'h04);
    sleep_mode <= 1'b1;
    tick(8);
    fall(7'h7B, 8'h01);
    fall(7'h77, 8'h00);
    sleep_mode <= 1'b0;
    tick(2);
    fall(7'h7B, 8'h00);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_sel();
    t_route();
    t_pb();
    t_rb();
    t_bitop();
    t_wake();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    stop_test();
  end
endmodule
